// [verilog/pmc_pkg.sv]
// Purpose: constants and types for the power-mode controller
// Assumes: 20 MHz core clock, register port with one-cycle read latency
// Notes: register offsets are byte addresses of 32-bit words
package pmc_pkg;

    typedef enum logic [2:0] {
        PMC_RUN,
        PMC_SLEEP,
        PMC_LP_RUN,
        PMC_LP_SLEEP,
        PMC_STOP,
        PMC_STANDBY,
        PMC_SHUTDOWN,
        PMC_WAKE_RESET
    } pmc_mode_e;

    // Register byte offsets
    localparam logic [7:0] PMC_CTRL_OFS = 8'h00;
    localparam logic [7:0] PMC_MON_OFS = 8'h04;
    localparam logic [7:0] PMC_PULLUP_OFS = 8'h08;
    localparam logic [7:0] PMC_PULLDN_OFS = 8'h0C;
    localparam logic [7:0] PMC_STATUS_OFS = 8'h10;
    localparam logic [7:0] PMC_FLAG_OFS = 8'h14;

    // Control fields
    localparam int PMC_CTRL_MODE_LSB = 0;
    localparam int PMC_CTRL_RANGE_LSB = 4;
    localparam int PMC_CTRL_WAKE_POL_BIT = 6;
    localparam int PMC_CTRL_CHARGE_BIT = 7;
    localparam int PMC_CTRL_DIV_LSB = 8;

    // Monitor fields
    localparam int PMC_MON_EN_BIT = 0;
    localparam int PMC_MON_FALL_BIT = 1;
    localparam int PMC_MON_RISE_BIT = 2;

    // Mode request codes written to the control register
    localparam logic [2:0] PMC_REQ_RUN = 3'h0;
    localparam logic [2:0] PMC_REQ_SLEEP = 3'h1;
    localparam logic [2:0] PMC_REQ_LP_RUN = 3'h2;
    localparam logic [2:0] PMC_REQ_LP_SLEEP = 3'h3;
    localparam logic [2:0] PMC_REQ_STOP = 3'h4;
    localparam logic [2:0] PMC_REQ_STANDBY = 3'h5;
    localparam logic [2:0] PMC_REQ_SHUTDOWN = 3'h6;

    // Voltage range codes
    localparam logic [1:0] PMC_RANGE1_BOOST = 2'h0;
    localparam logic [1:0] PMC_RANGE1_NORMAL = 2'h1;
    localparam logic [1:0] PMC_RANGE2 = 2'h2;

    // Processor clock limits in MHz, source clock in MHz
    localparam int PMC_SRC_MHZ = 170;
    localparam int PMC_LIM_BOOST_MHZ = 170;
    localparam int PMC_LIM_NORMAL_MHZ = 150;
    localparam int PMC_LIM_RANGE2_MHZ = 26;
    localparam int PMC_LIM_LP_MHZ = 2;
    // Least divider: source over limit, rounded up
    localparam logic [7:0] PMC_DIV_BOOST =
        8'((PMC_SRC_MHZ + PMC_LIM_BOOST_MHZ - 1) / PMC_LIM_BOOST_MHZ);
    localparam logic [7:0] PMC_DIV_NORMAL =
        8'((PMC_SRC_MHZ + PMC_LIM_NORMAL_MHZ - 1) / PMC_LIM_NORMAL_MHZ);
    localparam logic [7:0] PMC_DIV_RANGE2 =
        8'((PMC_SRC_MHZ + PMC_LIM_RANGE2_MHZ - 1) / PMC_LIM_RANGE2_MHZ);
    localparam logic [7:0] PMC_DIV_LP =
        8'((PMC_SRC_MHZ + PMC_LIM_LP_MHZ - 1) / PMC_LIM_LP_MHZ);

    // Length of the internal reset sequence after a deep wakeup
    localparam int PMC_CLK_MHZ = 20;
    localparam int PMC_WAKE_RST_NS = 1000;
    localparam int PMC_WAKE_RST_CYC = (PMC_WAKE_RST_NS * PMC_CLK_MHZ + 999) / 1000;

    localparam int PMC_TAMPER_N = 3;

    typedef struct packed {
        logic reset_pin;
        logic watchdog;
        logic wake_pin;
        logic rtc_event;
        logic slow_xtal_fail;
    } pmc_wake_s;

    typedef struct packed {
        logic main_regulator;
        logic low_power_regulator;
        logic cpu_clk_en;
        logic core_clk_en;
        logic pll_en;
        logic internal_fast_osc_en;
        logic fast_crystal_osc_en;
        logic internal_slow_osc_en;
        logic supply_drop_reset_en;
        logic core_powered;
    } pmc_power_s;

endpackage

// [verilog/pmc_power_mode_controller.sv]
// Purpose: power-mode sequencer and supply supervision controller
// Assumes: supply comparator levels and wake sources arrive asynchronously
// Notes: one clock domain, register port with read data one cycle later
`timescale 1ns/100ps
module pmc_power_mode_controller #(
    parameter int IO_N = 16,
    parameter int WAKE_RST_CYC = pmc_pkg::PMC_WAKE_RST_CYC
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    // Asynchronous inputs
    input wire logic main_supply_ok_i,
    input wire logic above_drop_level_i,
    input wire logic above_monitor_threshold_i,
    input wire logic irq_or_event_i,
    input wire pmc_pkg::pmc_wake_s wake_i,
    input wire logic fast_osc_request_i,
    input wire logic internal_reset_src_i,
    input wire logic [pmc_pkg::PMC_TAMPER_N-1:0] tamper_i,
    // Outputs
    output pmc_pkg::pmc_power_s power_o,
    output logic [7:0] cpu_clk_div_o,
    output logic [2:0] mode_o,
    output logic system_reset_o,
    output logic monitor_irq_o,
    output logic io_analog_o,
    output logic [IO_N-1:0] io_pullup_o,
    output logic [IO_N-1:0] io_pulldown_o,
    output logic reset_pin_pullup_o,
    output logic backup_on_battery_o,
    output logic battery_charge_o,
    output logic tamper_detect_o
);
    import pmc_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    localparam int SYN_N = 11 + PMC_TAMPER_N;
    logic [SYN_N-1:0] syn_raw;
    logic [SYN_N-1:0] syn1_reg;
    logic [SYN_N-1:0] syn2_reg;
    assign syn_raw = {tamper_i, internal_reset_src_i, fast_osc_request_i, wake_i,
                      irq_or_event_i, above_monitor_threshold_i, above_drop_level_i,
                      main_supply_ok_i};

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            syn1_reg <= '0;
            syn2_reg <= '0;
        end else begin
            syn1_reg <= syn_raw;
            syn2_reg <= syn1_reg;
        end
    end

    logic supply_ok;
    logic above_drop;
    logic above_mon;
    logic irq_ev;
    pmc_wake_s wake;
    logic fast_req;
    logic int_rst_src;
    logic [PMC_TAMPER_N-1:0] tamper;
    assign supply_ok = syn2_reg[0];
    assign above_drop = syn2_reg[1];
    assign above_mon = syn2_reg[2];
    assign irq_ev = syn2_reg[3];
    assign wake = syn2_reg[8:4];
    assign fast_req = syn2_reg[9];
    assign int_rst_src = syn2_reg[10];
    assign tamper = syn2_reg[SYN_N-1:11];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [2:0] req_mode_reg;
    logic [1:0] range_reg;
    logic wake_pol_reg;
    logic charge_en_reg;
    logic [7:0] div_reg;
    logic [2:0] mon_cfg_reg;
    logic [IO_N-1:0] pullup_cfg_reg;
    logic [IO_N-1:0] pulldn_cfg_reg;
    logic mon_flag_reg;
    logic mon_prev_reg;
    logic wake_prev_reg;
    logic req_pend_reg;
    pmc_mode_e mode_reg;
    logic [15:0] rst_cnt_reg;

    logic wr_ctrl;
    logic wr_flag;
    assign wr_ctrl = reg_write_i && (reg_addr_i == PMC_CTRL_OFS);
    assign wr_flag = reg_write_i && (reg_addr_i == PMC_FLAG_OFS);

    // Limit for the selected range, or the low-power limit in LP modes; slower divider is always honoured
    logic [7:0] div_min;
    always_comb begin
        if (mode_reg == PMC_LP_RUN || mode_reg == PMC_LP_SLEEP) begin
            div_min = PMC_DIV_LP;
        end else if (range_reg == PMC_RANGE1_BOOST) begin
            div_min = PMC_DIV_BOOST;
        end else if (range_reg == PMC_RANGE1_NORMAL) begin
            div_min = PMC_DIV_NORMAL;
        end else begin
            div_min = PMC_DIV_RANGE2;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            range_reg <= PMC_RANGE1_NORMAL;
            wake_pol_reg <= 1'b0;
            charge_en_reg <= 1'b0;
            div_reg <= PMC_DIV_RANGE2;
            mon_cfg_reg <= '0;
            pullup_cfg_reg <= '0;
            pulldn_cfg_reg <= '0;
        end else if (system_reset_o) begin
            range_reg <= PMC_RANGE1_NORMAL;
            wake_pol_reg <= 1'b0;
            charge_en_reg <= 1'b0;
            div_reg <= PMC_DIV_RANGE2;
            mon_cfg_reg <= '0;
        end else if (reg_write_i) begin
            if (reg_addr_i == PMC_CTRL_OFS) begin
                range_reg <= reg_wdata_i[PMC_CTRL_RANGE_LSB +: 2];
                wake_pol_reg <= reg_wdata_i[PMC_CTRL_WAKE_POL_BIT];
                charge_en_reg <= reg_wdata_i[PMC_CTRL_CHARGE_BIT];
                div_reg <= reg_wdata_i[PMC_CTRL_DIV_LSB +: 8];
            end else if (reg_addr_i == PMC_MON_OFS) begin
                mon_cfg_reg <= reg_wdata_i[2:0];
            end else if (reg_addr_i == PMC_PULLUP_OFS) begin
                pullup_cfg_reg <= reg_wdata_i[IO_N-1:0];
            end else if (reg_addr_i == PMC_PULLDN_OFS) begin
                pulldn_cfg_reg <= reg_wdata_i[IO_N-1:0];
            end
        end
    end

    // Software mode request, consumed by the sequencer
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            req_mode_reg <= PMC_REQ_RUN;
            req_pend_reg <= 1'b0;
        end else if (wr_ctrl) begin
            req_mode_reg <= reg_wdata_i[PMC_CTRL_MODE_LSB +: 3];
            req_pend_reg <= 1'b1;
        end else begin
            req_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Supply threshold monitor
    // ----------------------------------------------------------------
    logic mon_hit;
    assign mon_hit = mon_cfg_reg[PMC_MON_EN_BIT] && mode_reg != PMC_SHUTDOWN &&
                     ((mon_cfg_reg[PMC_MON_FALL_BIT] && mon_prev_reg && !above_mon) ||
                      (mon_cfg_reg[PMC_MON_RISE_BIT] && !mon_prev_reg && above_mon));

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mon_prev_reg <= 1'b0;
            mon_flag_reg <= 1'b0;
        end else begin
            mon_prev_reg <= above_mon;
            if (mon_hit) begin
                mon_flag_reg <= 1'b1;
            end else if (wr_flag && reg_wdata_i[0]) begin
                mon_flag_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Wake detection
    // ----------------------------------------------------------------
    logic wake_lvl;
    logic wake_edge;
    logic deep_exit;
    assign wake_lvl = wake.wake_pin ^ wake_pol_reg;
    assign wake_edge = wake_lvl && !wake_prev_reg;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_prev_reg <= 1'b0;
        end else begin
            wake_prev_reg <= wake_lvl;
        end
    end

    // Battery-only operation blocks every wake source; exit needs the supply back and a wake
    always_comb begin
        deep_exit = 1'b0;
        if (supply_ok) begin
            if (mode_reg == PMC_STANDBY) begin
                deep_exit = wake.reset_pin || wake.watchdog || wake_edge ||
                            wake.rtc_event || wake.slow_xtal_fail;
            end else if (mode_reg == PMC_SHUTDOWN) begin
                deep_exit = wake.reset_pin || wake.watchdog || wake_edge ||
                            wake.rtc_event;
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode sequencer
    // ----------------------------------------------------------------
    logic drop_hold;
    assign drop_hold = !above_drop && mode_reg != PMC_SHUTDOWN;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_reg <= PMC_RUN;
            rst_cnt_reg <= '0;
        end else if (drop_hold) begin
            mode_reg <= PMC_RUN;
            rst_cnt_reg <= '0;
        end else begin
            case (mode_reg)
                PMC_RUN: begin
                    if (req_pend_reg) begin
                        if (req_mode_reg == PMC_REQ_SLEEP) begin
                            mode_reg <= PMC_SLEEP;
                        end else if (req_mode_reg == PMC_REQ_LP_RUN) begin
                            mode_reg <= PMC_LP_RUN;
                        end else if (req_mode_reg == PMC_REQ_STOP) begin
                            mode_reg <= PMC_STOP;
                        end else if (req_mode_reg == PMC_REQ_STANDBY) begin
                            mode_reg <= PMC_STANDBY;
                        end else if (req_mode_reg == PMC_REQ_SHUTDOWN) begin
                            mode_reg <= PMC_SHUTDOWN;
                        end
                    end
                end
                PMC_SLEEP: begin
                    if (irq_ev) begin
                        mode_reg <= PMC_RUN;
                    end
                end
                PMC_LP_RUN: begin
                    if (req_pend_reg) begin
                        if (req_mode_reg == PMC_REQ_RUN) begin
                            mode_reg <= PMC_RUN;
                        end else if (req_mode_reg == PMC_REQ_LP_SLEEP) begin
                            mode_reg <= PMC_LP_SLEEP;
                        end else if (req_mode_reg == PMC_REQ_STOP) begin
                            mode_reg <= PMC_STOP;
                        end else if (req_mode_reg == PMC_REQ_STANDBY) begin
                            mode_reg <= PMC_STANDBY;
                        end else if (req_mode_reg == PMC_REQ_SHUTDOWN) begin
                            mode_reg <= PMC_SHUTDOWN;
                        end
                    end
                end
                PMC_LP_SLEEP: begin
                    if (irq_ev) begin
                        mode_reg <= PMC_LP_RUN;
                    end
                end
                PMC_STOP: begin
                    if (irq_ev) begin
                        mode_reg <= PMC_RUN;
                    end
                end
                PMC_STANDBY, PMC_SHUTDOWN: begin
                    if (deep_exit) begin
                        mode_reg <= PMC_WAKE_RESET;
                        rst_cnt_reg <= '0;
                    end
                end
                PMC_WAKE_RESET: begin
                    if (rst_cnt_reg == 16'(WAKE_RST_CYC - 1)) begin
                        mode_reg <= PMC_RUN;
                    end else begin
                        rst_cnt_reg <= rst_cnt_reg + 16'h0001;
                    end
                end
                default: begin
                    mode_reg <= PMC_RUN;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Power, clock and pin outputs
    // ----------------------------------------------------------------
    pmc_power_s pwr;
    always_comb begin
        pwr = '0;
        pwr.supply_drop_reset_en = 1'b1;
        pwr.internal_slow_osc_en = 1'b1;
        case (mode_reg)
            PMC_RUN, PMC_WAKE_RESET: begin
                pwr.main_regulator = 1'b1;
                pwr.cpu_clk_en = 1'b1;
                pwr.core_clk_en = 1'b1;
                pwr.pll_en = 1'b1;
                pwr.internal_fast_osc_en = 1'b1;
                pwr.fast_crystal_osc_en = 1'b1;
                pwr.core_powered = 1'b1;
            end
            PMC_SLEEP: begin
                pwr.main_regulator = 1'b1;
                pwr.core_clk_en = 1'b1;
                pwr.pll_en = 1'b1;
                pwr.internal_fast_osc_en = 1'b1;
                pwr.fast_crystal_osc_en = 1'b1;
                pwr.core_powered = 1'b1;
            end
            PMC_LP_RUN: begin
                pwr.low_power_regulator = 1'b1;
                pwr.cpu_clk_en = 1'b1;
                pwr.core_clk_en = 1'b1;
                pwr.internal_fast_osc_en = 1'b1;
                pwr.core_powered = 1'b1;
            end
            PMC_LP_SLEEP: begin
                pwr.low_power_regulator = 1'b1;
                pwr.core_clk_en = 1'b1;
                pwr.internal_fast_osc_en = 1'b1;
                pwr.core_powered = 1'b1;
            end
            PMC_STOP: begin
                pwr.low_power_regulator = 1'b1;
                pwr.internal_fast_osc_en = fast_req;
                pwr.core_powered = 1'b1;
            end
            PMC_STANDBY: begin
                pwr.supply_drop_reset_en = 1'b1;
            end
            PMC_SHUTDOWN: begin
                pwr.supply_drop_reset_en = 1'b0;
                pwr.internal_slow_osc_en = 1'b0;
            end
            default: begin
                pwr.main_regulator = 1'b1;
            end
        endcase
    end

    logic in_reset;
    assign in_reset = drop_hold || mode_reg == PMC_WAKE_RESET;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            power_o <= '0;
            cpu_clk_div_o <= PMC_DIV_RANGE2;
            mode_o <= PMC_REQ_RUN;
            system_reset_o <= 1'b1;
            monitor_irq_o <= 1'b0;
            io_analog_o <= 1'b1;
            io_pullup_o <= '0;
            io_pulldown_o <= '0;
            reset_pin_pullup_o <= 1'b1;
            backup_on_battery_o <= 1'b0;
            battery_charge_o <= 1'b0;
            tamper_detect_o <= 1'b0;
        end else begin
            power_o <= pwr;
            cpu_clk_div_o <= (div_reg < div_min) ? div_min : div_reg;
            mode_o <= 3'(mode_reg);
            system_reset_o <= in_reset;
            monitor_irq_o <= mon_flag_reg;
            // Pins stay analog during reset and for one cycle after system_reset_o clears
            io_analog_o <= in_reset || system_reset_o;
            if (mode_reg == PMC_STANDBY) begin
                io_pullup_o <= pullup_cfg_reg;
                io_pulldown_o <= pulldn_cfg_reg & ~pullup_cfg_reg;
            end else begin
                io_pullup_o <= '0;
                io_pulldown_o <= '0;
            end
            reset_pin_pullup_o <= !int_rst_src;
            backup_on_battery_o <= !supply_ok;
            battery_charge_o <= charge_en_reg && supply_ok;
            tamper_detect_o <= |tamper;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= '0;
        end else if (reg_read_i) begin
            if (reg_addr_i == PMC_CTRL_OFS) begin
                reg_rdata_o <= {16'h0000, div_reg, charge_en_reg, wake_pol_reg,
                                range_reg, 1'b0, req_mode_reg};
            end else if (reg_addr_i == PMC_MON_OFS) begin
                reg_rdata_o <= {29'h0, mon_cfg_reg};
            end else if (reg_addr_i == PMC_PULLUP_OFS) begin
                reg_rdata_o <= 32'(pullup_cfg_reg);
            end else if (reg_addr_i == PMC_PULLDN_OFS) begin
                reg_rdata_o <= 32'(pulldn_cfg_reg);
            end else if (reg_addr_i == PMC_STATUS_OFS) begin
                reg_rdata_o <= {24'h0, !supply_ok, above_mon, supply_ok,
                                system_reset_o, 1'b0, 3'(mode_reg)};
            end else if (reg_addr_i == PMC_FLAG_OFS) begin
                reg_rdata_o <= {31'h0, mon_flag_reg};
            end else begin
                reg_rdata_o <= '0;
            end
        end else begin
            reg_rdata_o <= '0;
        end
    end

endmodule

// [tb/pmc_asserts.sv]
// Purpose: port-level property checks for the power-mode controller
// Assumes: mode and power outputs settle together after a mode change
// Notes: bound from the testbench top file
`timescale 1ns/100ps
module pmc_asserts #(
    parameter int IO_N = 16
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic internal_reset_src_i,
    input wire logic [pmc_pkg::PMC_TAMPER_N-1:0] tamper_i,
    input wire pmc_pkg::pmc_power_s power_o,
    input wire logic [7:0] cpu_clk_div_o,
    input wire logic [2:0] mode_o,
    input wire logic system_reset_o,
    input wire logic io_analog_o,
    input wire logic [IO_N-1:0] io_pullup_o,
    input wire logic [IO_N-1:0] io_pulldown_o,
    input wire logic reset_pin_pullup_o,
    input wire logic backup_on_battery_o,
    input wire logic battery_charge_o,
    input wire logic tamper_detect_o
);
    import pmc_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    // ------
    // Checks
    // ------
    run_start_a: assert property ($past(reset_i) |-> mode_o == PMC_RUN)
        else $error("not in run after reset");
    lp_supply_a: assert property (mode_o == PMC_LP_RUN && $past(mode_o) == PMC_LP_RUN
        |-> power_o.low_power_regulator && !power_o.main_regulator && cpu_clk_div_o >= PMC_DIV_LP)
        else $error("low-power run setting wrong");
    stop_gate_a: assert property (mode_o == PMC_STOP && $past(mode_o) == PMC_STOP
        |-> !power_o.core_clk_en && !power_o.pll_en && !power_o.fast_crystal_osc_en)
        else $error("clock running in stop");
    standby_off_a: assert property (mode_o == PMC_STANDBY && $past(mode_o) == PMC_STANDBY
        |-> !power_o.main_regulator && !power_o.low_power_regulator
        && power_o.supply_drop_reset_en && !power_o.core_powered) else $error("standby power");
    shutdown_off_a: assert property (mode_o == PMC_SHUTDOWN && $past(mode_o) == PMC_SHUTDOWN
        |-> !power_o.internal_slow_osc_en && !power_o.supply_drop_reset_en)
        else $error("shutdown supervision left on");
    pull_gate_a: assert property (mode_o != PMC_STANDBY && $past(mode_o) != PMC_STANDBY
        |-> io_pullup_o == '0 && io_pulldown_o == '0) else $error("pulls outside standby");
    charge_gate_a: assert property (battery_charge_o |-> !backup_on_battery_o)
        else $error("charging on battery");
    tamper_live_a: assert property ((tamper_i != '0) [*4] |-> tamper_detect_o)
        else $error("tamper missed");
    pin_pullup_a: assert property (internal_reset_src_i [*4] |-> !reset_pin_pullup_o)
        else $error("reset pin pull-up on");
    io_analog_a: assert property (system_reset_o [*2] |-> io_analog_o)
        else $error("I/O not analog in reset");
    cover property (mode_o == PMC_WAKE_RESET);
    cover property (mode_o == PMC_SHUTDOWN);
    cover property (tamper_detect_o && backup_on_battery_o);
endmodule

// [tb/tb_power_mode_controller.sv]
// Purpose: directed test of the power-mode controller
// Assumes: wake reset shortened to 4 cycles
// Notes: modes watched at mode_o, registers through the strobe port
`timescale 1ns/100ps
module tb_power_mode_controller;
    import pmc_pkg::*;
    logic core_clk_i = 0, reset_i = 1, reg_write_i = 0, reg_read_i = 0;
    logic [7:0] reg_addr_i = 8'h00, cpu_clk_div_o;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
    logic main_supply_ok_i = 1, above_drop_level_i = 1, above_monitor_threshold_i = 1;
    logic irq_or_event_i = 0, fast_osc_request_i = 0, internal_reset_src_i = 0;
    logic [2:0] tamper_i = 3'h0, mode_o;
    pmc_wake_s wake_i = 5'h00;
    pmc_power_s power_o;
    logic system_reset_o, monitor_irq_o, io_analog_o, reset_pin_pullup_o;
    logic backup_on_battery_o, battery_charge_o, tamper_detect_o;
    logic [15:0] io_pullup_o, io_pulldown_o;
    int error_cnt = 0, total_checks = 0;
    pmc_power_mode_controller #(.IO_N(16), .WAKE_RST_CYC(4)) i_dut (.*);
    initial forever #25 core_clk_i = ~core_clk_i;
    // -----
    // Tasks
    // -----
    task end_sim();
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            error_cnt++;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_write_i <= 1'h1;
        @(posedge core_clk_i);
        reg_write_i <= 1'h0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'h1;
        @(posedge core_clk_i);
        reg_read_i <= 1'h0;
        #1 d = reg_rdata_o;
    endtask
    task wm(input logic [2:0] m);
        int i;
        for (i = 0; i < 99 && mode_o !== m; i++) @(posedge core_clk_i) #1;
        chk(32'(mode_o), 32'(m));
        if (i == 99) end_sim();
        @(posedge core_clk_i) #1;
    endtask
    task pulse(input logic [5:0] v);
        @(posedge core_clk_i);
        {irq_or_event_i, wake_i} <= v;
        repeat (3) @(posedge core_clk_i);
        {irq_or_event_i, wake_i} <= 6'h00;
    endtask
    task hold(input logic [7:0] a, input logic [31:0] v);
        wr(a, v);
        repeat (5) @(posedge core_clk_i) #1;
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'h0;
        repeat (4) @(posedge core_clk_i);
        rd(PMC_STATUS_OFS);
        chk(d & 32'hB7, 32'h20);
        hold(PMC_CTRL_OFS, 32'h3);
        chk(32'(mode_o), 32'h0);
        hold(PMC_CTRL_OFS, 32'h0320);
        chk(32'(cpu_clk_div_o), 32'(PMC_DIV_RANGE2));
        hold(PMC_CTRL_OFS, 32'h0A10);
        chk(32'(cpu_clk_div_o), 32'h0A);
        wr(PMC_CTRL_OFS, 32'h2);
        wm(PMC_LP_RUN);
        chk(32'(cpu_clk_div_o), 32'(PMC_DIV_LP));
        chk(32'({power_o.main_regulator, power_o.low_power_regulator}), 32'h1);
        wr(PMC_CTRL_OFS, 32'h3);
        wm(PMC_LP_SLEEP);
        pulse(6'h20);
        wm(PMC_LP_RUN);
        wr(PMC_CTRL_OFS, 32'h0);
        wm(PMC_RUN);
        wr(PMC_CTRL_OFS, 32'h1);
        wm(PMC_SLEEP);
        chk(32'({power_o.cpu_clk_en, power_o.core_clk_en}), 32'h1);
        pulse(6'h20);
        wm(PMC_RUN);
        wr(PMC_CTRL_OFS, 32'h4);
        wm(PMC_STOP);
        chk(32'(power_o.internal_fast_osc_en), 32'h0);
        fast_osc_request_i <= 1'h1;
        repeat (5) @(posedge core_clk_i) #1;
        chk(32'(power_o.internal_fast_osc_en), 32'h1);
        fast_osc_request_i <= 1'h0;
        pulse(6'h20);
        wm(PMC_RUN);
        wr(PMC_PULLUP_OFS, 32'h00F0);
        wr(PMC_PULLDN_OFS, 32'h0FF0);
        wr(PMC_CTRL_OFS, 32'h5);
        wm(PMC_STANDBY);
        chk({io_pullup_o, io_pulldown_o}, 32'h00F00F00);
        pulse(6'h01);
        wm(PMC_WAKE_RESET);
        chk(32'(system_reset_o), 32'h1);
        wm(PMC_RUN);
        wr(PMC_CTRL_OFS, 32'h6);
        wm(PMC_SHUTDOWN);
        pulse(6'h01);
        repeat (6) @(posedge core_clk_i) #1;
        chk(32'(mode_o), 32'(PMC_SHUTDOWN));
        main_supply_ok_i <= 1'h0;
        pulse(6'h02);
        repeat (6) @(posedge core_clk_i) #1;
        chk(32'(mode_o), 32'(PMC_SHUTDOWN));
        main_supply_ok_i <= 1'h1;
        pulse(6'h04);
        wm(PMC_WAKE_RESET);
        wm(PMC_RUN);
        wr(PMC_MON_OFS, 32'h3);
        above_monitor_threshold_i <= 1'h0;
        repeat (5) @(posedge core_clk_i) #1;
        chk(32'(monitor_irq_o), 32'h1);
        above_monitor_threshold_i <= 1'h1;
        wr(PMC_FLAG_OFS, 32'h1);
        rd(PMC_FLAG_OFS);
        chk(d, 32'h0);
        chk(32'(monitor_irq_o), 32'h0);
        internal_reset_src_i <= 1'h1;
        tamper_i <= 3'h4;
        main_supply_ok_i <= 1'h0;
        hold(PMC_CTRL_OFS, 32'h80);
        chk(32'({reset_pin_pullup_o, backup_on_battery_o, battery_charge_o, tamper_detect_o}),
            32'h5);
        internal_reset_src_i <= 1'h0;
        main_supply_ok_i <= 1'h1;
        hold(PMC_CTRL_OFS, 32'h80);
        chk(32'(battery_charge_o), 32'h1);
        above_drop_level_i <= 1'h0;
        repeat (5) @(posedge core_clk_i) #1;
        chk(32'({system_reset_o, io_analog_o}), 32'h3);
        above_drop_level_i <= 1'h1;
        wm(PMC_RUN);
        end_sim();
    end
endmodule
bind pmc_power_mode_controller pmc_asserts #(.IO_N(IO_N)) i_chk (.*);
